// ===== bij_pkg.sv
// Constants, opcode patterns and carrier types for the bit-scan,
// increment and jump execution slice. Assumes 24-bit instruction words.
package bij_pkg;
   // Opcode match masks and patterns
   localparam logic [23:0] OPM_SQUARE_DIFF_ACCUMULATE_OP = 24'hfc4c03;
   localparam logic [23:0] OPP_SQUARE_DIFF_ACCUMULATE_OP = 24'hf04002;
   localparam logic [23:0] OPM_SWAP = 24'hfff870;
   localparam logic [23:0] OPP_SWAP = 24'hfd0000;
   localparam logic [23:0] OPM_SCAN = 24'hfff800;
   localparam logic [23:0] OPP_SCBL = 24'hdf0000;
   localparam logic [23:0] OPP_SCLO = 24'hcf8000;
   localparam logic [23:0] OPP_SCRO = 24'hcf0000;
   localparam logic [23:0] OPM_JMPD = 24'hff0001;
   localparam logic [23:0] OPP_JMPD = 24'h040000;
   localparam logic [23:0] OPM_JMPI = 24'hfffff0;
   localparam logic [23:0] OPP_JMPI = 24'h014000;
   localparam logic [23:0] OPM_INC  = 24'hff8000;
   localparam logic [23:0] OPP_INCF = 24'hec0000;
   localparam logic [23:0] OPP_INCW = 24'he80000;
   // Field positions
   localparam int BYTE_BIT = 14;
   localparam int DIR_BIT  = 13;
   localparam int ACC_BIT  = 15;
   // Register offsets (byte addresses) and control reset value
   localparam logic [7:0] OFS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_STAT  = 8'h04;
   localparam logic [7:0] OFS_ACALO = 8'h08;
   localparam logic [7:0] OFS_ACAHI = 8'h0c;
   localparam logic [7:0] OFS_ACBLO = 8'h10;
   localparam logic [7:0] OFS_ACBHI = 8'h14;
   localparam logic [2:0] CTRL_RST  = 3'h0;
   // Status bit positions
   localparam int ST_C = 0, ST_Z = 1, ST_OV = 2, ST_N = 3, ST_DC = 4;
   localparam int ST_SB = 8, ST_SA = 9, ST_OB = 10, ST_OA = 11;
   localparam int ST_SAB = 12, ST_OAB = 13;
   // Saturation limits
   localparam logic [39:0] SAT_POS  = 40'h007fffffff;
   localparam logic [39:0] SAT_NEG  = 40'hff80000000;
   localparam logic [39:0] SSAT_POS = 40'h7fffffffff;
   localparam logic [39:0] SSAT_NEG = 40'h8000000000;
   // Cycles per jump (issue plus one bubble)
   localparam int JUMP_CYC = 2;
   // Write destinations
   typedef enum logic [1:0] {
      KIND_W = 2'h0, KIND_FILE = 2'h1, KIND_WORKING_ACCUMULATOR_REG = 2'h2
   } bij_kind_t;
   typedef struct packed {
      logic        en;
      bij_kind_t   kind;
      logic [12:0] addr;
      logic [2:0]  mode;
      logic [1:0]  byteEn;
      logic [15:0] data;
   } bij_wr_t;
   typedef struct packed {
      logic either_acc_overflow, either_acc_clipped, oa, ob, sa, sb, dc, n, ov, z, c;
   } bij_flags_t;
endpackage

// ===== bij_scan.sv
// Three word bit scans on one 16-bit operand, purely combinational.
// Assumes the operand is already fetched through its addressing mode.
`timescale 1ns/10ps
`default_nettype none
module bij_scan (
   // Operand
   input  wire logic [15:0] op,
   // Results and carries
   output logic      [15:0] chgRes,
   output logic             chgNone,
   output logic      [15:0] loRes,
   output logic             loNone,
   output logic      [15:0] roRes,
   output logic             roNone
);
   // Later loop hits overwrite, giving the priority each scan needs
   always_comb begin
      chgRes = 16'hfff1;
      chgNone = 1'b1;
      loRes = 16'h0000;
      loNone = 1'b1;
      roRes = 16'h0000;
      roNone = 1'b1;
      for (int i = 0; i < 15; i++) begin
         if (op[i] != op[15]) begin
            chgRes = 16'(i - 14);
            chgNone = 1'b0;
         end
      end
      for (int i = 0; i < 16; i++) begin
         if (op[i]) begin
            loRes = 16'(16 - i);
            loNone = 1'b0;
         end
      end
      for (int i = 15; i >= 0; i--) begin
         if (op[i]) begin
            roRes = 16'(i + 1);
            roNone = 1'b0;
         end
      end
   end
endmodule // bij_scan
`default_nettype wire

// ===== bij_acc.sv
// 40-bit accumulate with optional normal or super saturation.
// Assumes the addend is already sign-extended to 40 bits.
`timescale 1ns/10ps
`default_nettype none
module bij_acc (
   // Operands and mode
   input  wire logic [39:0] acc,
   input  wire logic [39:0] addend,
   input  wire logic        satEn,
   input  wire logic        superSat,
   // Result and flags
   output logic      [39:0] res,
   output logic             ovf,
   output logic             clip
);
   logic [40:0] sum;
   logic        ovf39;
   logic        big;
   assign sum = {acc[39], acc} + {addend[39], addend};
   assign ovf39 = sum[40] ^ sum[39];
   assign big = ovf39 | ~((&sum[39:31]) | ~(|sum[39:31]));
   // Without saturation a wrap past bit 39 still counts as clipping
   always_comb begin
      res = sum[39:0];
      clip = ovf39;
      if (satEn && superSat && ovf39) begin
         res = sum[40] ? bij_pkg::SSAT_NEG : bij_pkg::SSAT_POS;
      end else if (satEn && !superSat) begin
         clip = big;
         if (big) begin
            res = sum[40] ? bij_pkg::SAT_NEG : bij_pkg::SAT_POS;
         end
      end
      ovf = ~((&res[39:31]) | ~(|res[39:31]));
   end
endmodule // bij_acc
`default_nettype wire

// ===== bij_exec.sv
// Execution slice: accumulate, swap, scans, jumps and increments,
// with an APB slave for saturation control and flag/accumulator view.
// Assumes decoder supplies resolved operands with each issued word.
//
// Contract
// - Decode accumulate opcode ending 10, one cycle.
// - Swap two W registers, flags kept.
// - Sign-change scan writes result, carry only.
// - Bit 14 is zero, lower negative; clear carry.
// - No change gives FFF1 and carry set.
// - Leading-one scan numbers 1..16, none gives zero.
// - Trailing-one scan zero-extended position to target.
// - Trailing numbering bit 0 is 1, bit15 16.
// - Trailing none writes zero, sets carry, else clears.
// - Trailing decode differs in third nibble; carry only.
// - Scans and swap are word-only operations.
// - Direct jump loads 23-bit literal, kills fetch.
// - Indirect jump loads pointer bits, high zero.
// - Increments update half-carry, N, OV, Z, C.
// - Register increment with mode fields, byte option.
`timescale 1ns/10ps
`default_nettype none
module bij_exec (
   // Clock and reset
   input  wire logic                clock,
   input  wire logic                sys_rst,
   // Instruction issue
   input  wire logic                instrValid,
   output logic                     instrReady,
   input  wire logic [23:0]         instrWord,
   input  wire logic [23:0]         instrWord2,
   // Resolved operands
   input  wire logic [15:0]         opSrc,
   input  wire logic [15:0]         opDst,
   input  wire logic [15:0]         opWm,
   input  wire logic [15:0]         opX,
   input  wire logic [15:0]         opY,
   input  wire logic                srcHiByte,
   input  wire logic                dstHiByte,
   // Register file writes
   output bij_pkg::bij_wr_t         wrA,
   output bij_pkg::bij_wr_t         wrB,
   // Prefetch requests
   output logic                     pfStrobe,
   output logic      [3:0]          pfXop,
   output logic      [3:0]          pfYop,
   // Program counter
   output logic                     pcLoad,
   output logic      [22:0]         pcNext,
   output logic                     fetchKill,
   // Flags and accumulators
   output bij_pkg::bij_flags_t      flags,
   output logic      [39:0]         accumulator_a,
   output logic      [39:0]         accumulator_b,
   // APB slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr
);
   typedef enum logic [1:0] {
      ST_RUN  = 2'b01,
      ST_JUMP = 2'b10
   } bij_state_t;

   // Every check below runs on the core clock, idle in reset
   default clocking chkClk @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   bij_state_t          state_q;
   bij_pkg::bij_flags_t flags_q;
   bij_pkg::bij_flags_t flags_d;
   bij_pkg::bij_wr_t    wrA_q;
   bij_pkg::bij_wr_t    wrB_q;
   logic [39:0]         accumulator_a_q;
   logic [39:0]         accumulator_b_q;
   logic [2:0]          ctrl_q;
   logic [31:0]         prdata_q;
   logic                perr_q;
   logic                fire;
   logic isEdac, isSwap, isChg, isLo, isRo, isJd, isJi, isIncF, isIncW;
   logic [15:0] chgRes, loRes, roRes;
   logic        chgNone, loNone, roNone;
   logic [39:0] sqExt, accIn, accRes;
   logic [31:0] sqProd;
   logic        accOvf, accClip, tgtB;
   logic        byteMode, srcLane, dstLane;
   logic [7:0]  byteIn;
   logic [16:0] incW;
   logic [8:0]  incB;
   logic        apbWr, apbSetup;

   assign fire = instrValid & instrReady;
   assign instrReady = (state_q == ST_RUN);

   // Opcode decode, every scan and swap pattern is word-only
   always_comb begin
      isEdac = fire && ((instrWord & bij_pkg::OPM_SQUARE_DIFF_ACCUMULATE_OP)
               == bij_pkg::OPP_SQUARE_DIFF_ACCUMULATE_OP);
      isSwap = fire && ((instrWord & bij_pkg::OPM_SWAP)
               == bij_pkg::OPP_SWAP);
      isChg = fire && ((instrWord & bij_pkg::OPM_SCAN)
              == bij_pkg::OPP_SCBL);
      isLo = fire && ((instrWord & bij_pkg::OPM_SCAN)
             == bij_pkg::OPP_SCLO);
      isRo = fire && ((instrWord & bij_pkg::OPM_SCAN)
             == bij_pkg::OPP_SCRO);
      isJd = fire && ((instrWord & bij_pkg::OPM_JMPD)
             == bij_pkg::OPP_JMPD);
      isJi = fire && ((instrWord & bij_pkg::OPM_JMPI)
             == bij_pkg::OPP_JMPI);
      isIncF = fire && ((instrWord & bij_pkg::OPM_INC)
               == bij_pkg::OPP_INCF);
      isIncW = fire && ((instrWord & bij_pkg::OPM_INC)
               == bij_pkg::OPP_INCW);
   end

   bij_scan u_scan (
      .op      (opSrc),
      .chgRes  (chgRes),
      .chgNone (chgNone),
      .loRes   (loRes),
      .loNone  (loNone),
      .roRes   (roRes),
      .roNone  (roNone)
   );

   // Operands widened before the product so no square bit is lost;
   // the low 32 product bits do not depend on signedness
   assign sqProd = {{16{opWm[15]}}, opWm} * {{16{opWm[15]}}, opWm};
   assign sqExt = {{8{sqProd[31]}}, sqProd};
   assign tgtB = instrWord[bij_pkg::ACC_BIT];
   assign accIn = tgtB ? accumulator_b_q : accumulator_a_q;

   bij_acc u_acc (
      .acc      (accIn),
      .addend   (sqExt),
      .satEn    (tgtB ? ctrl_q[1] : ctrl_q[0]),
      .superSat (ctrl_q[2]),
      .res      (accRes),
      .ovf      (accOvf),
      .clip     (accClip)
   );

   // Increment arithmetic, byte lane picked by the operand address
   assign byteMode = instrWord[bij_pkg::BYTE_BIT];
   assign srcLane = isIncF ? instrWord[0] : srcHiByte;
   assign dstLane = isIncF ? (instrWord[bij_pkg::DIR_BIT]
                    & instrWord[0]) : dstHiByte;
   assign byteIn = srcLane ? opSrc[15:8] : opSrc[7:0];
   assign incW = {1'b0, opSrc} + 17'h00001;
   assign incB = {1'b0, byteIn} + 9'h001;

   // Sequencer, jumps hold issue off for one bubble
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= ST_RUN;
      end else begin
         case (state_q)
            ST_RUN: begin
               if (isJd || isJi) begin
                  state_q <= ST_JUMP;
               end
            end
            ST_JUMP: state_q <= ST_RUN;
            default: state_q <= ST_RUN;
         endcase
      end
   end

   // Program counter load and fetch kill pulses
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         pcLoad <= 1'b0;
         fetchKill <= 1'b0;
         pcNext <= 23'h000000;
      end else begin
         pcLoad <= isJd | isJi;
         fetchKill <= isJd | isJi;
         if (isJd) begin
            pcNext <= {instrWord2[6:0], instrWord[15:1], 1'b0};
         end else if (isJi) begin
            pcNext <= {7'h00, opSrc[15:1], 1'b0};
         end
      end
   end

   // Register file write ports, one-cycle strobes
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         wrA_q <= '0;
         wrB_q <= '0;
      end else begin
         wrA_q <= '0;
         wrB_q <= '0;
         if (isEdac) begin
            wrA_q.en <= 1'b1;
            wrA_q.kind <= bij_pkg::KIND_W;
            wrA_q.addr <= {9'h000, 2'b01, instrWord[13:12]};
            wrA_q.byteEn <= 2'b11;
            wrA_q.data <= opX - opY;
         end else if (isSwap) begin
            wrA_q.en <= 1'b1;
            wrA_q.kind <= bij_pkg::KIND_W;
            wrA_q.addr <= {9'h000, instrWord[10:7]};
            wrA_q.byteEn <= 2'b11;
            wrA_q.data <= opSrc;
            wrB_q.en <= 1'b1;
            wrB_q.kind <= bij_pkg::KIND_W;
            wrB_q.addr <= {9'h000, instrWord[3:0]};
            wrB_q.byteEn <= 2'b11;
            wrB_q.data <= opDst;
         end else if (isChg || isLo || isRo) begin
            wrA_q.en <= 1'b1;
            wrA_q.kind <= bij_pkg::KIND_W;
            wrA_q.addr <= {9'h000, instrWord[10:7]};
            wrA_q.byteEn <= 2'b11;
            wrA_q.data <= isChg ? chgRes
                          : (isLo ? loRes : roRes);
         end else if (isIncF || isIncW) begin
            wrA_q.en <= 1'b1;
            if (isIncF) begin
               wrA_q.kind <= instrWord[bij_pkg::DIR_BIT] ?
                             bij_pkg::KIND_FILE : bij_pkg::KIND_WORKING_ACCUMULATOR_REG;
               wrA_q.addr <= instrWord[12:0];
            end else begin
               wrA_q.kind <= bij_pkg::KIND_W;
               wrA_q.addr <= {9'h000, instrWord[10:7]};
               wrA_q.mode <= instrWord[13:11];
            end
            if (byteMode) begin
               wrA_q.byteEn <= dstLane ? 2'b10 : 2'b01;
               wrA_q.data <= {incB[7:0], incB[7:0]};
            end else begin
               wrA_q.byteEn <= 2'b11;
               wrA_q.data <= incW[15:0];
            end
         end
      end
   end

   // Prefetch field hand-off for the address generator
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         pfStrobe <= 1'b0;
         pfXop <= 4'h0;
         pfYop <= 4'h0;
      end else begin
         pfStrobe <= isEdac;
         if (isEdac) begin
            pfXop <= instrWord[9:6];
            pfYop <= instrWord[5:2];
         end
      end
   end

   // Accumulators, only the selected one moves
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         accumulator_a_q <= 40'h0000000000;
         accumulator_b_q <= 40'h0000000000;
      end else if (isEdac) begin
         if (tgtB) begin
            accumulator_b_q <= accRes;
         end else begin
            accumulator_a_q <= accRes;
         end
      end
   end

   // Flag next value; clipped bits stick, set beats software clear
   always_comb begin
      flags_d = flags_q;
      if (apbWr && paddr == bij_pkg::OFS_STAT) begin
         flags_d.sa = flags_q.sa & ~pwdata[bij_pkg::ST_SA];
         flags_d.sb = flags_q.sb & ~pwdata[bij_pkg::ST_SB];
      end
      if (isEdac) begin
         if (tgtB) begin
            flags_d.ob = accOvf;
            flags_d.sb = flags_d.sb | accClip;
         end else begin
            flags_d.oa = accOvf;
            flags_d.sa = flags_d.sa | accClip;
         end
      end
      if (isChg) begin
         flags_d.c = chgNone;
      end
      if (isLo) begin
         flags_d.c = loNone;
      end
      if (isRo) begin
         flags_d.c = roNone;
      end
      if (isIncF || isIncW) begin
         if (byteMode) begin
            flags_d.c = incB[8];
            flags_d.z = (incB[7:0] == 8'h00);
            flags_d.n = incB[7];
            flags_d.ov = (byteIn == 8'h7f);
            flags_d.dc = &byteIn[3:0];
         end else begin
            flags_d.c = incW[16];
            flags_d.z = (incW[15:0] == 16'h0000);
            flags_d.n = incW[15];
            flags_d.ov = (opSrc == 16'h7fff);
            flags_d.dc = &opSrc[7:0];
         end
      end
      flags_d.either_acc_overflow = flags_d.oa | flags_d.ob;
      flags_d.either_acc_clipped = flags_d.sa | flags_d.sb;
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         flags_q <= '0;
      end else begin
         flags_q <= flags_d;
      end
   end

   // APB: zero wait, read data captured in the setup cycle
   assign apbSetup = psel & ~penable;
   assign apbWr = psel & penable & pwrite;
   assign pready = 1'b1;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q <= bij_pkg::CTRL_RST;
      end else if (apbWr && paddr == bij_pkg::OFS_CTRL) begin
         ctrl_q <= pwdata[2:0];
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         prdata_q <= 32'h00000000;
         perr_q <= 1'b0;
      end else if (apbSetup) begin
         perr_q <= 1'b0;
         case (paddr)
            bij_pkg::OFS_CTRL:  prdata_q <= {29'h0, ctrl_q};
            bij_pkg::OFS_STAT:  prdata_q <= {18'h0, flags_q.either_acc_overflow,
               flags_q.either_acc_clipped, flags_q.oa, flags_q.ob, flags_q.sa,
               flags_q.sb, 3'h0, flags_q.dc, flags_q.n, flags_q.ov,
               flags_q.z, flags_q.c};
            bij_pkg::OFS_ACALO: prdata_q <= accumulator_a_q[31:0];
            bij_pkg::OFS_ACAHI: prdata_q <= {24'h0, accumulator_a_q[39:32]};
            bij_pkg::OFS_ACBLO: prdata_q <= accumulator_b_q[31:0];
            bij_pkg::OFS_ACBHI: prdata_q <= {24'h0, accumulator_b_q[39:32]};
            default: begin
               prdata_q <= 32'h00000000;
               perr_q <= 1'b1;
            end
         endcase
      end
   end

   assign prdata = prdata_q;
   assign pslverr = perr_q & psel & penable;
   assign wrA = wrA_q;
   assign wrB = wrB_q;
   assign flags = flags_q;
   assign accumulator_a = accumulator_a_q;
   assign accumulator_b = accumulator_b_q;

   // Checks
   a_swap_data: assert property (
      isSwap |=> wrA.en && wrB.en && wrA.data == $past(opSrc)
      && wrB.data == $past(opDst) && flags.c == $past(flags.c))
      else $error("swap result wrong");
   a_chg_none: assert property (
      isChg && (opSrc == 16'hffff || opSrc == 16'h0000)
      |=> wrA.data == 16'hfff1 && flags.c)
      else $error("sign scan no-change wrong");
   a_chg_found: assert property (
      isChg && opSrc == 16'hff0a |=> wrA.data == 16'hfff9 && !flags.c)
      else $error("sign scan position wrong");
   a_scan_zflag: assert property (
      (isChg || isLo || isRo) |=> $stable(flags.z) && $stable(flags.n))
      else $error("scan touched flags");
   a_lo_none: assert property (
      isLo && opSrc == 16'h0000 |=> wrA.data == 16'h0000 && flags.c)
      else $error("leading scan empty wrong");
   a_ro_pos: assert property (
      isRo && opSrc == 16'h8000 |=> wrA.data == 16'h0010 && !flags.c)
      else $error("trailing scan position wrong");
   a_ro_none: assert property (
      isRo && opSrc == 16'h0000 |=> wrA.data == 16'h0000 && flags.c)
      else $error("trailing scan empty wrong");
   a_jump_direct: assert property (
      isJd |=> pcLoad && fetchKill && !instrReady && pcNext ==
      {$past(instrWord2[6:0]), $past(instrWord[15:1]), 1'b0}
      ##1 instrReady)
      else $error("direct jump wrong");
   a_jump_ind: assert property (
      isJi |=> pcLoad && pcNext[22:16] == 7'h00 && !pcNext[0]
      && pcNext[15:1] == $past(opSrc[15:1]))
      else $error("indirect jump wrong");
   a_inc_byte: assert property (
      (isIncF || isIncW) && byteMode |=> $onehot(wrA.byteEn))
      else $error("byte increment lane wrong");
   a_square_diff_accumulate_op_diff: assert property (
      isEdac |=> wrA.data == $past(opX) - $past(opY) && pfStrobe)
      else $error("difference write wrong");
   c_square_diff_accumulate_op: cover property (@(posedge clock) disable iff (sys_rst)
      isEdac ##1 flags.oa);
   c_jump: cover property (@(posedge clock) disable iff (sys_rst)
      isJd ##2 isIncW);
   c_clip: cover property (@(posedge clock) disable iff (sys_rst)
      isEdac ##1 flags.either_acc_clipped);
endmodule // bij_exec
`default_nettype wire

// ===== test_bitscan_inc_jump_exec.sv
// Self-checking bench for the execution slice: scans, swap, jumps,
// increments, accumulate and saturation, register port over APB.
// Assumes bij_pkg and the design modules are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_bitscan_inc_jump_exec;
   logic                clock, sys_rst, instrValid, instrReady;
   logic                psel, penable, pwrite, pready, pslverr, errSeen;
   logic                pfStrobe, pcLoad, fetchKill, srcHiByte, dstHiByte;
   logic [23:0]         instrWord, instrWord2;
   logic [15:0]         opSrc, opDst, opWm, opX, opY;
   logic [7:0]          paddr;
   logic [31:0]         pwdata, prdata, rdVal;
   logic [3:0]          pfXop, pfYop;
   logic [22:0]         pcNext;
   logic [39:0]         accumulator_a, accumulator_b;
   bij_pkg::bij_wr_t    wrA, wrB;
   bij_pkg::bij_flags_t flags;
   int                  n_fail = 0;
   int                  checks_done = 0;

   bij_exec i_bij_exec (.clock(clock), .sys_rst(sys_rst),
      .instrValid(instrValid), .instrReady(instrReady),
      .instrWord(instrWord), .instrWord2(instrWord2), .opSrc(opSrc),
      .opDst(opDst), .opWm(opWm), .opX(opX), .opY(opY),
      .srcHiByte(srcHiByte), .dstHiByte(dstHiByte), .wrA(wrA),
      .wrB(wrB), .pfStrobe(pfStrobe), .pfXop(pfXop), .pfYop(pfYop),
      .pcLoad(pcLoad), .pcNext(pcNext), .fetchKill(fetchKill),
      .flags(flags), .accumulator_a(accumulator_a), .accumulator_b(accumulator_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   // Free-running 250 MHz clock
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task automatic complete_run;
      if (n_fail == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [39:0] exp, got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   // One issue; returns just after the answer edge so strobes are seen
   task automatic issue(input logic [23:0] w, w2);
      @(posedge clock);
      instrValid <= 1'b1;
      instrWord  <= w;
      instrWord2 <= w2;
      do begin
         @(posedge clock);
      end while (instrReady !== 1'b1);
      instrValid <= 1'b0;
      #1;
   endtask

   // Request held until pready is sampled high, never a fixed count
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clock);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rdVal   = prdata;
      errSeen = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic scan(input logic [23:0] op, input logic [15:0] src,
                       res, input logic cy);
      opSrc = src;
      issue(op | 24'h000481, 24'h0);
      chk("scan write", 1'b1, wrA.en);
      chk("scan result", res, wrA.data);
      chk("scan carry", cy, flags.c);
   endtask

   task automatic t_scans;
      scan(bij_pkg::OPP_SCBL, 16'hff0a, 16'hfff9, 1'b0);
      scan(bij_pkg::OPP_SCBL, 16'h55ff, 16'h0000, 1'b0);
      scan(bij_pkg::OPP_SCBL, 16'hffff, 16'hfff1, 1'b1);
      scan(bij_pkg::OPP_SCLO, 16'h000a, 16'h000d, 1'b0);
      scan(bij_pkg::OPP_SCLO, 16'h0000, 16'h0000, 1'b1);
      scan(bij_pkg::OPP_SCRO, 16'h000a, 16'h0002, 1'b0);
      scan(bij_pkg::OPP_SCRO, 16'h8000, 16'h0010, 1'b0);
      scan(bij_pkg::OPP_SCRO, 16'h0000, 16'h0000, 1'b1);
      issue(bij_pkg::OPP_SCRO | 24'h004481, 24'h0);
      chk("byte scan", 1'b0, wrA.en);
   endtask

   // Word to file, byte to working reg, then register form
   task automatic t_incr;
      opSrc = 16'h7fff;
      issue(bij_pkg::OPP_INCF | 24'h002800, 24'h0);
      chk("inc f data", 16'h8000, wrA.data);
      chk("inc f kind", bij_pkg::KIND_FILE, wrA.kind);
      chk("inc f flags", 5'b11100, {flags.dc, flags.n, flags.ov,
          flags.z, flags.c});
      opSrc = 16'h8fff;
      issue(bij_pkg::OPP_INCF | 24'h005000, 24'h0);
      chk("inc b kind", bij_pkg::KIND_WORKING_ACCUMULATOR_REG, wrA.kind);
      chk("inc b lane", 2'b01, wrA.byteEn);
      chk("inc b data", 8'h00, wrA.data[7:0]);
      chk("inc b flags", 5'b10011, {flags.dc, flags.n, flags.ov,
          flags.z, flags.c});
      opSrc = 16'hff7f;
      {srcHiByte, dstHiByte} = 2'b11;
      issue(bij_pkg::OPP_INCW | 24'h004101, 24'h0);
      chk("inc hi lane", 18'h20000, {wrA.byteEn, wrA.data});
      chk("inc hi flags", 5'b10011, {flags.dc, flags.n, flags.ov,
          flags.z, flags.c});
      issue(bij_pkg::OPP_INCW | 24'h000101, 24'h0);
      chk("inc w data", 16'hff80, wrA.data);
      chk("inc w kind", bij_pkg::KIND_W, wrA.kind);
      chk("inc w flags", 5'b01000, {flags.dc, flags.n, flags.ov,
          flags.z, flags.c});
   endtask

   task automatic t_swap;
      opSrc = 16'h55ff;
      opDst = 16'ha3a3;
      issue(bij_pkg::OPP_SWAP | 24'h000481, 24'h0);
      chk("swap W9", 16'h55ff, (wrA.addr === 13'd9) ? wrA.data
          : wrB.data);
      chk("swap W1", 16'ha3a3, (wrA.addr === 13'd1) ? wrA.data
          : wrB.data);
      chk("swap addr", {13'h0009, 13'h0001}, {wrA.addr, wrB.addr});
      chk("swap flags", 5'b01000, {flags.dc, flags.n, flags.ov,
          flags.z, flags.c});
   endtask

   task automatic t_jumps;
      issue(24'h047844, 24'h000002);
      chk("jump pc", 23'h027844, pcNext);
      chk("jump kill", 2'b11, {pcLoad, fetchKill});
      chk("jump bubble", 1'b0, instrReady);
      @(posedge clock);
      #1;
      chk("jump resume", 1'b1, instrReady);
      opSrc = 16'h7845;
      issue(bij_pkg::OPP_JMPI | 24'h000004, 24'h0);
      chk("ind pc", 23'h007844, pcNext);
      chk("ind load", 1'b1, pcLoad);
   endtask

   // Two accumulates, then two saturating ones with clipping on B
   task automatic t_acc;
      opWm = 16'h43c2;
      opX  = 16'h6a7c;
      opY  = 16'h2b3d;
      issue(24'hf1d106, 24'h0);
      chk("acc diff", 16'h3f3f, wrA.data);
      chk("acc fetch", 9'h141, {pfStrobe, pfXop, pfYop});
      issue(24'hf1d106, 24'h0);
      chk("acc sum", 40'h0023de3e08, accumulator_b);
      apb(1'b0, bij_pkg::OFS_ACBLO, 32'h0);
      chk("acc lo", 32'h23de3e08, rdVal);
      apb(1'b1, bij_pkg::OFS_CTRL, 32'h2);
      opWm = 16'h8000;
      repeat (2) issue(24'hf1d106, 24'h0);
      chk("acc sat", bij_pkg::SAT_POS, accumulator_b);
      chk("acc clip", 2'b11, {flags.sb, flags.either_acc_clipped});
      chk("acc a kept", 40'h0000000000, accumulator_a);
      apb(1'b0, bij_pkg::OFS_STAT, 32'h0);
      chk("stat", 32'h00001108, rdVal);
      apb(1'b1, bij_pkg::OFS_STAT, 32'h00000100);
      apb(1'b0, bij_pkg::OFS_STAT, 32'h0);
      chk("stat clear", 32'h00000008, rdVal);
   endtask

   task automatic t_regs;
      apb(1'b0, bij_pkg::OFS_CTRL, 32'h0);
      chk("ctrl reset", 32'h0, rdVal);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped err", 1'b1, errSeen);
   endtask

   // Watchdog ends a hang through the same closing task
   initial begin
      #40000;
      n_fail++;
      complete_run();
   end

   initial begin
      {instrValid, psel, penable, pwrite, srcHiByte, dstHiByte} = 6'h00;
      {instrWord, instrWord2} = 48'h0;
      {opSrc, opDst, opWm, opX, opY} = 80'h0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      sys_rst = 1'b1;
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      t_regs();
      t_scans();
      t_incr();
      t_swap();
      t_jumps();
      t_acc();
      complete_run();
   end
endmodule // test_bitscan_inc_jump_exec
`default_nettype wire
